// >>> pkg/sscp_pkg.sv
// How it works
// R1 - Each opcode is shifted into an 8-bit holder on serial clock rising edges.
// R2 - Host holds select low for the whole operation; raising it ends it.
// R3 - Opcode, address and data all move most significant bit first.
// R4 - Mode field bits 7:6 pick access type; 00 means single-byte access.
// R5 - Byte access: opcode, 24-bit address, then exactly one data byte.
// R6 - Mode 10: address steps within a 32-byte page and wraps at its end.
// R7 - Mode 01: address steps across pages and wraps from top to zero.
// R8 - Only the low 17 of the 24 address bits locate a byte.
// R9 - Opcode 03h plus address shifts the stored byte out.
// R10 - Sequential read keeps supplying bytes, address stepping and wrapping to zero.
// R11 - A read lasts until select rises, for as many clocks as given.
// R12 - Opcode 02h plus address stores data bytes until select rises.
// R13 - Page write keeps accepting bytes, overwriting the page after 32.
// R14 - Sequential write accepts bytes forever, wrapping to zero and overwriting.
// R15 - Opcode 3Bh switches to two bits per clock on lines 0 and 1.
// R16 - Opcode 38h switches to four bits per clock on lines 0 to 3.
// R17 - Opcode FFh returns from dual or quad to single-bit transfers.
// R18 - Opcode 05h shifts out the mode byte; low six bits read zero.
// R19 - Opcode 01h loads the next byte into the mode field.
// R20 - Mode field resets to sequential; pattern 11 is rejected as invalid.
// R21 - After reset nothing starts until select goes from high to low.
// R22 - Dual and quad modes carry opcode, address and data at full width.
// R23 - Unknown opcodes are ignored with outputs released until deselect.
package sscp_pkg;

   localparam int         ADDR_BITS  = 17;
   localparam int         PAGE_BITS  = 5;
   localparam int         PIN_W      = 4;
   localparam logic [4:0] CMD_BITS   = 5'h08;
   localparam logic [4:0] ADDR_FIELD = 5'h18;
   localparam logic [4:0] DATA_BITS  = 5'h08;

   // Opcodes.
   localparam logic [7:0] OP_READ       = 8'h03;
   localparam logic [7:0] OP_WRITE      = 8'h02;
   localparam logic [7:0] ENTER_DUAL    = 8'h3B;
   localparam logic [7:0] ENTER_QUAD    = 8'h38;
   localparam logic [7:0] EXIT_WIDE     = 8'hFF;
   localparam logic [7:0] MODE_READ_OP  = 8'h05;
   localparam logic [7:0] MODE_WRITE_OP = 8'h01;

   // Access mode field, held in bits 7:6 of the mode byte.
   localparam int         MODE_HI    = 7;
   localparam int         MODE_LO    = 6;
   localparam logic [1:0] MODE_BYTE  = 2'h0;
   localparam logic [1:0] MODE_PAGE  = 2'h2;
   localparam logic [1:0] MODE_SEQ   = 2'h1;
   localparam logic [1:0] MODE_RSVD  = 2'h3;
   localparam logic [5:0] MODE_ZEROS = 6'h00;

   typedef enum logic [1:0] {
      BUS_SINGLE = 2'b00,
      BUS_DUAL   = 2'b01,
      BUS_QUAD   = 2'b10
   } sscp_bus_e;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_CMD    = 3'b001,
      ST_ADDR   = 3'b010,
      ST_WDATA  = 3'b011,
      ST_RDATA  = 3'b100,
      ST_MODER  = 3'b101,
      ST_MODEW  = 3'b110,
      ST_IGNORE = 3'b111
   } sscp_state_e;

endpackage

// >>> rtl/sscp_core.sv
module sscp_core #(
   parameter int AW = sscp_pkg::ADDR_BITS,
   parameter int PW = sscp_pkg::PAGE_BITS
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       cs_n,
   input  wire logic       sck,
   input  wire logic [3:0] sio_in,
   output      logic [3:0] sio_out,
   output      logic [3:0] sio_oe_n
);

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Bits moved per serial clock in each bus mode.
   function automatic logic [4:0] sscp_width(input sscp_pkg::sscp_bus_e bus);
      unique case (bus)
         sscp_pkg::BUS_DUAL: sscp_width = 5'h02;
         sscp_pkg::BUS_QUAD: sscp_width = 5'h04;
         default:            sscp_width = 5'h01;
      endcase
   endfunction

   // Shifts new bits in at the bottom so the first bit ends up on top.
   function automatic logic [23:0] sscp_shift(input logic [23:0] sh,
                                              input logic [3:0] pins,
                                              input sscp_pkg::sscp_bus_e bus);
      unique case (bus)
         sscp_pkg::BUS_DUAL: sscp_shift = {sh[21:0], pins[1:0]};
         sscp_pkg::BUS_QUAD: sscp_shift = {sh[19:0], pins};
         default:            sscp_shift = {sh[22:0], pins[0]};
      endcase
   endfunction

   // Places the top bits of a byte on the lines used by the bus mode.
   function automatic logic [3:0] sscp_pins(input logic [7:0] b,
                                            input sscp_pkg::sscp_bus_e bus);
      unique case (bus)
         sscp_pkg::BUS_DUAL: sscp_pins = {2'h0, b[7:6]};
         sscp_pkg::BUS_QUAD: sscp_pins = b[7:4];
         default:            sscp_pins = {2'h0, b[7], 1'h0};
      endcase
   endfunction

   // Active-low enables for the lines that carry read data.
   function automatic logic [3:0] sscp_oe(input sscp_pkg::sscp_bus_e bus);
      unique case (bus)
         sscp_pkg::BUS_DUAL: sscp_oe = 4'hC;
         sscp_pkg::BUS_QUAD: sscp_oe = 4'h0;
         default:            sscp_oe = 4'hD;
      endcase
   endfunction

   // Address step after each byte; page mode keeps the page number.
   function automatic logic [AW-1:0] sscp_next(input logic [AW-1:0] a,
                                               input logic [1:0] mode);
      if (mode == sscp_pkg::MODE_PAGE) begin
         sscp_next = {a[AW-1:PW], a[PW-1:0] + 1'b1};
      end else if (mode == sscp_pkg::MODE_SEQ) begin
         sscp_next = a + 1'b1;
      end else begin
         sscp_next = a;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection.

   logic       cs_s1_q, cs_s2_q, cs_prev_q;
   logic       sck_s1_q, sck_s2_q, sck_s3_q;
   logic [3:0] sio_s1_q, sio_s2_q;
   logic       sck_rise, sck_fall, cs_start;

   // Select, clock and data pass two flops; the edge detectors read the second and a third flop of select and clock.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cs_s1_q   <= 1'b0;
         cs_s2_q   <= 1'b0;
         cs_prev_q <= 1'b0;
         sck_s1_q  <= 1'b0;
         sck_s2_q  <= 1'b0;
         sck_s3_q  <= 1'b0;
         sio_s1_q  <= 4'h0;
         sio_s2_q  <= 4'h0;
      end else begin
         cs_s1_q   <= cs_n;
         cs_s2_q   <= cs_s1_q;
         cs_prev_q <= cs_s2_q;
         sck_s1_q  <= sck;
         sck_s2_q  <= sck_s1_q;
         sck_s3_q  <= sck_s2_q;
         sio_s1_q  <= sio_in;
         sio_s2_q  <= sio_s1_q;
      end
   end

   // Data passes the same two stages as the clock, so it stays aligned to its edge.
   assign sck_rise = sck_s2_q & ~sck_s3_q;
   assign sck_fall = ~sck_s2_q & sck_s3_q;
   // All select stages reset low, so a select already low at reset gives no false start.
   assign cs_start = cs_prev_q & ~cs_s2_q; // R21

   ////////////////////////////////////////////////////////////////////////////
   // Command sequencer.

   sscp_pkg::sscp_state_e state_q, state_d;
   sscp_pkg::sscp_bus_e   bus_q, bus_d;
   logic [4:0]            cnt_q, cnt_d, cnt_nx, bw, ocnt_q, ocnt_d, ocnt_nx;
   logic [23:0]           sh_q, sh_d, sh_in;
   logic [AW-1:0]         addr_q, addr_d;
   logic [1:0]            mode_q, mode_d;
   logic [7:0]            obuf_q, obuf_d, cur_byte, mem_rd_q;
   logic                  rd_q, rd_d, drv_q, drv_d, done_q, done_d, mem_we;
   logic [3:0]            sio_out_q, sio_out_d, sio_oe_n_q, sio_oe_n_d;
   logic [7:0]            mem_q [0:(2**AW)-1];

   assign bw      = sscp_width(bus_q); // R22
   assign sh_in   = sscp_shift(sh_q, sio_s2_q, bus_q); // R1 R3 R22
   assign cnt_nx  = cnt_q + bw;
   assign ocnt_nx = ocnt_q + bw;

   // Next-state logic; a raised select overrides everything and ends the operation.
   always_comb begin
      state_d   = state_q;
      bus_d     = bus_q;
      cnt_d     = cnt_q;
      sh_d      = sh_q;
      addr_d    = addr_q;
      mode_d    = mode_q;
      obuf_d    = obuf_q;
      ocnt_d    = ocnt_q;
      rd_d      = rd_q;
      drv_d     = drv_q;
      done_d    = done_q;
      sio_out_d = sio_out_q;
      mem_we    = 1'b0;
      cur_byte  = obuf_q;
      if (cs_s2_q) begin
         state_d = sscp_pkg::ST_IDLE; // R2 R11
         drv_d   = 1'b0;
      end else begin
         unique case (state_q)
            sscp_pkg::ST_IDLE: begin
               if (cs_start) begin
                  state_d = sscp_pkg::ST_CMD; // R21
                  cnt_d   = 5'h00;
               end
            end
            sscp_pkg::ST_CMD: begin
               if (sck_rise) begin
                  sh_d  = sh_in;
                  cnt_d = cnt_nx;
                  if (cnt_nx == sscp_pkg::CMD_BITS) begin
                     cnt_d  = 5'h00;
                     ocnt_d = 5'h00;
                     done_d = 1'b0;
                     unique case (sh_in[7:0])
                        sscp_pkg::OP_READ: begin
                           state_d = sscp_pkg::ST_ADDR; // R9
                           rd_d    = 1'b1;
                        end
                        sscp_pkg::OP_WRITE: begin
                           state_d = sscp_pkg::ST_ADDR; // R12
                           rd_d    = 1'b0;
                        end
                        sscp_pkg::MODE_READ_OP:  state_d = sscp_pkg::ST_MODER; // R18
                        sscp_pkg::MODE_WRITE_OP: state_d = sscp_pkg::ST_MODEW; // R19
                        sscp_pkg::ENTER_DUAL: begin
                           bus_d   = sscp_pkg::BUS_DUAL; // R15
                           state_d = sscp_pkg::ST_IGNORE;
                        end
                        sscp_pkg::ENTER_QUAD: begin
                           bus_d   = sscp_pkg::BUS_QUAD; // R16
                           state_d = sscp_pkg::ST_IGNORE;
                        end
                        sscp_pkg::EXIT_WIDE: begin
                           bus_d   = sscp_pkg::BUS_SINGLE; // R17
                           state_d = sscp_pkg::ST_IGNORE;
                        end
                        default: state_d = sscp_pkg::ST_IGNORE; // R23
                     endcase
                  end
               end
            end
            sscp_pkg::ST_ADDR: begin
               if (sck_rise) begin
                  sh_d  = sh_in;
                  cnt_d = cnt_nx;
                  if (cnt_nx == sscp_pkg::ADDR_FIELD) begin
                     cnt_d   = 5'h00;
                     addr_d  = sh_in[AW-1:0]; // R8 R5
                     state_d = rd_q ? sscp_pkg::ST_RDATA : sscp_pkg::ST_WDATA;
                  end
               end
            end
            sscp_pkg::ST_WDATA: begin
               if (sck_rise) begin
                  sh_d  = sh_in;
                  cnt_d = cnt_nx;
                  if (cnt_nx == sscp_pkg::DATA_BITS) begin
                     cnt_d  = 5'h00;
                     mem_we = 1'b1; // R12
                     addr_d = sscp_next(addr_q, mode_q); // R6 R7 R13 R14
                     if (mode_q == sscp_pkg::MODE_BYTE) begin
                        state_d = sscp_pkg::ST_IGNORE; // R4 R5
                     end
                  end
               end
            end
            sscp_pkg::ST_MODEW: begin
               if (sck_rise) begin
                  sh_d  = sh_in;
                  cnt_d = cnt_nx;
                  if (cnt_nx == sscp_pkg::DATA_BITS) begin
                     cnt_d   = 5'h00;
                     state_d = sscp_pkg::ST_IGNORE;
                     if (sh_in[sscp_pkg::MODE_HI:sscp_pkg::MODE_LO] != sscp_pkg::MODE_RSVD) begin
                        mode_d = sh_in[sscp_pkg::MODE_HI:sscp_pkg::MODE_LO]; // R19 R20
                     end
                  end
               end
            end
            sscp_pkg::ST_RDATA, sscp_pkg::ST_MODER: begin
               // Output changes only on falling edges so the host samples a stable level.
               if (sck_fall) begin
                  if (done_q && ocnt_q == 5'h00) begin
                     state_d = sscp_pkg::ST_IGNORE; // R4 R5
                     drv_d   = 1'b0;
                  end else begin
                     if (ocnt_q != 5'h00) begin
                        cur_byte = obuf_q;
                     end else if (state_q == sscp_pkg::ST_RDATA) begin
                        cur_byte = mem_rd_q; // R9 R10
                     end else begin
                        cur_byte = {mode_q, sscp_pkg::MODE_ZEROS}; // R18
                     end
                     sio_out_d = sscp_pins(cur_byte, bus_q); // R3 R22
                     obuf_d    = cur_byte << bw;
                     drv_d     = 1'b1;
                     ocnt_d    = ocnt_nx;
                     if (ocnt_nx == sscp_pkg::DATA_BITS) begin
                        ocnt_d = 5'h00;
                        if (state_q == sscp_pkg::ST_RDATA) begin
                           addr_d = sscp_next(addr_q, mode_q); // R10 R6 R7
                           done_d = (mode_q == sscp_pkg::MODE_BYTE);
                        end
                     end
                  end
               end
            end
            sscp_pkg::ST_IGNORE: begin
               drv_d = 1'b0; // R23
            end
         endcase
      end
      sio_oe_n_d = drv_d ? sscp_oe(bus_q) : 4'hF; // R11 R23
   end

   // Registers of the sequencer.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q    <= sscp_pkg::ST_IDLE;
         bus_q      <= sscp_pkg::BUS_SINGLE;
         cnt_q      <= 5'h00;
         sh_q       <= 24'h000000;
         addr_q     <= '0;
         mode_q     <= sscp_pkg::MODE_SEQ; // R20
         obuf_q     <= 8'h00;
         ocnt_q     <= 5'h00;
         rd_q       <= 1'b0;
         drv_q      <= 1'b0;
         done_q     <= 1'b0;
         sio_out_q  <= 4'h0;
         sio_oe_n_q <= 4'hF;
      end else begin
         state_q    <= state_d;
         bus_q      <= bus_d;
         cnt_q      <= cnt_d;
         sh_q       <= sh_d;
         addr_q     <= addr_d;
         mode_q     <= mode_d;
         obuf_q     <= obuf_d;
         ocnt_q     <= ocnt_d;
         rd_q       <= rd_d;
         drv_q      <= drv_d;
         done_q     <= done_d;
         sio_out_q  <= sio_out_d;
         sio_oe_n_q <= sio_oe_n_d;
      end
   end

   // The array has no reset; the read port runs every cycle, well ahead of the next fall.
   always_ff @(posedge clk) begin
      if (mem_we) begin
         mem_q[addr_q] <= sh_in[7:0]; // R12 R13 R14
      end
      mem_rd_q <= mem_q[addr_q];
   end

   assign sio_out  = sio_out_q;
   assign sio_oe_n = sio_oe_n_q;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   deselect_release_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
      cs_s2_q |-> ##1 (sio_oe_n_q == 4'hF && state_q == sscp_pkg::ST_IDLE))
      else $error("Outputs not released after deselect.");

   mode_default_a: assert property (@(posedge clk) disable iff (!rst_n) // R20
      $rose(rst_n) |-> mode_q == sscp_pkg::MODE_SEQ)
      else $error("Mode field not sequential after reset.");

   read_decode_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
      (!cs_s2_q && state_q == sscp_pkg::ST_CMD && sck_rise && cnt_nx == sscp_pkg::CMD_BITS
       && sh_in[7:0] == sscp_pkg::OP_READ) |=> (state_q == sscp_pkg::ST_ADDR && rd_q))
      else $error("Read opcode not decoded.");

   quad_enter_a: assert property (@(posedge clk) disable iff (!rst_n) // R16
      (!cs_s2_q && state_q == sscp_pkg::ST_CMD && sck_rise && cnt_nx == sscp_pkg::CMD_BITS
       && sh_in[7:0] == sscp_pkg::ENTER_QUAD) |=> bus_q == sscp_pkg::BUS_QUAD)
      else $error("Quad mode not entered.");

   wide_exit_a: assert property (@(posedge clk) disable iff (!rst_n) // R17
      (!cs_s2_q && state_q == sscp_pkg::ST_CMD && sck_rise && cnt_nx == sscp_pkg::CMD_BITS
       && sh_in[7:0] == sscp_pkg::EXIT_WIDE) |=> bus_q == sscp_pkg::BUS_SINGLE)
      else $error("Single-bit mode not restored.");

   addr_mask_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
      (!cs_s2_q && state_q == sscp_pkg::ST_ADDR && sck_rise
       && cnt_nx == sscp_pkg::ADDR_FIELD) |=> addr_q == $past(sh_in[AW-1:0]))
      else $error("Address not taken from the low bits.");

   page_wrap_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
      (mem_we && mode_q == sscp_pkg::MODE_PAGE)
      |=> (addr_q[AW-1:PW] == $past(addr_q[AW-1:PW])
           && addr_q[PW-1:0] == $past(addr_q[PW-1:0]) + 1'b1))
      else $error("Page address left its page.");

   seq_wrap_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
      (mem_we && mode_q == sscp_pkg::MODE_SEQ && addr_q == {AW{1'b1}}) |=> addr_q == '0)
      else $error("Sequential address did not wrap to zero.");

   byte_stop_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
      (mem_we && mode_q == sscp_pkg::MODE_BYTE) |=> state_q == sscp_pkg::ST_IGNORE)
      else $error("Byte access accepted a second byte.");

   ignore_hiz_a: assert property (@(posedge clk) disable iff (!rst_n) // R23
      state_q == sscp_pkg::ST_IGNORE |-> sio_oe_n_q == 4'hF)
      else $error("Output driven while ignoring.");

   mode_write_a: assert property (@(posedge clk) disable iff (!rst_n) // R19
      (!cs_s2_q && state_q == sscp_pkg::ST_MODEW && sck_rise
       && cnt_nx == sscp_pkg::DATA_BITS && sh_in[7:6] != sscp_pkg::MODE_RSVD)
      |=> mode_q == $past(sh_in[7:6]))
      else $error("Mode write not stored.");

endmodule

// >>> tb/serial_sram_command_port_bench.sv
module serial_sram_command_port_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk;
   logic        rst_n;
   logic        cs_n;
   logic        sck;
   logic [3:0]  sio_in;
   logic [3:0]  sio_out;
   logic [3:0]  sio_oe_n;
   logic [3:0]  host_drv;
   logic [31:0] r;
   logic [1:0]  amode;
   logic [7:0]  mem [int];
   int          n_errors;
   int          n_checks;

   // The system clock at 200 MHz.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   sscp_core i_dut (
      .clk      (clk),
      .rst_n    (rst_n),
      .cs_n     (cs_n),
      .sck      (sck),
      .sio_in   (sio_in),
      .sio_out  (sio_out),
      .sio_oe_n (sio_oe_n)
   );

   sscp_host i_host (
      .clk      (clk),
      .sio_wire (sio_in),
      .cs_n     (cs_n),
      .sck      (sck),
      .host_drv (host_drv)
   );

   // Each line carries the device value where its enable is low, else the host's.
   assign sio_in = (sio_out & ~sio_oe_n) | (host_drv & sio_oe_n);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Expected address step for the access mode currently held by the model.
   function automatic logic [16:0] next_a(input logic [16:0] a);
      if (amode == sscp_pkg::MODE_PAGE) return {a[16:5], a[4:0] + 5'h01};
      if (amode == sscp_pkg::MODE_SEQ) return a + 17'h00001;
      return a;
   endfunction

   function automatic logic [3:0] oe_exp(input int w);
      return (w == 1) ? 4'hD : ((w == 2) ? 4'hC : 4'h0);
   endfunction

   // One framed command with an optional trailing byte sent or received.
   task automatic cmd(input int w, input logic [7:0] op, input int n, input logic [7:0] v,
                      input bit drv);
      i_host.frame_open();
      i_host.shift(w, 8, 32'(op), 1'b1, r);
      i_host.shift(w, n, 32'(v), drv, r);
      i_host.frame_close();
   endtask

   // Reserved low bits are always written as zero.
   task automatic set_mode(input logic [1:0] m);
      cmd(1, sscp_pkg::MODE_WRITE_OP, 8, {m, 6'h00}, 1'b1);
      amode = m;
   endtask

   task automatic mem_write(input int w, input logic [23:0] a, input int n);
      logic [16:0] p;
      logic [7:0]  d;
      p = a[16:0];
      i_host.frame_open();
      i_host.shift(w, 8, 32'(sscp_pkg::OP_WRITE), 1'b1, r);
      i_host.shift(w, 24, {8'h00, a}, 1'b1, r);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         i_host.shift(w, 8, 32'(d), 1'b1, r);
         if (amode != sscp_pkg::MODE_BYTE || i == 0) mem[p] = d;
         p = next_a(p);
      end
      i_host.frame_close();
   endtask

   task automatic mem_read(input int w, input logic [23:0] a, input int n);
      logic [16:0] p;
      p = a[16:0];
      i_host.frame_open();
      i_host.shift(w, 8, 32'(sscp_pkg::OP_READ), 1'b1, r);
      i_host.shift(w, 24, {8'h00, a}, 1'b1, r);
      for (int i = 0; i < n; i++) begin
         i_host.shift(w, 8, 32'h0, 1'b0, r);
         chk("read byte", r[7:0], mem[p]);
         p = next_a(p);
      end
      chk("drive enable", sio_oe_n, oe_exp(w));
      if (amode == sscp_pkg::MODE_BYTE) begin
         i_host.shift(w, 8, 32'h0, 1'b0, r);
         chk("byte release", sio_oe_n, 4'hF);
      end
      i_host.frame_close();
      chk("deselect release", sio_oe_n, 4'hF);
   endtask

   task automatic mode_chk(input int w);
      i_host.frame_open();
      i_host.shift(w, 8, 32'(sscp_pkg::MODE_READ_OP), 1'b1, r);
      i_host.shift(w, 16, 32'h0, 1'b0, r);
      i_host.frame_close();
      chk("mode byte", r[15:0], {2{amode, 6'h00}});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, mode field, three access modes, bad opcode, wide buses.
   initial begin
      logic [23:0] a;
      rst_n    = 1'b0;
      n_errors = 0;
      n_checks = 0;
      amode    = sscp_pkg::MODE_SEQ;
      void'($urandom(26));
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      chk("reset release", sio_oe_n, 4'hF);
      mode_chk(1);
      cmd(1, sscp_pkg::MODE_WRITE_OP, 8, 8'hC0, 1'b1);
      mode_chk(1);
      // Write to mid-array (0FFFEh) with junk in the ignored address bits; read from the top (1FFFEh).
      mem_write(1, 24'hFE_FFFE, 3);
      mem_read(1, 24'h01_FFFE, 3);
      set_mode(sscp_pkg::MODE_PAGE);
      mode_chk(1);
      a = {7'h55, 17'($urandom)};
      mem_write(1, a, 34);
      mem_read(1, a, 33);
      set_mode(sscp_pkg::MODE_BYTE);
      mem_write(1, 24'h01_FFFE, 2);
      mem_read(1, 24'h01_FFFE, 1);
      mem_read(1, 24'h01_FFFF, 1);
      // An unknown opcode must leave every line released for the rest of the frame.
      i_host.frame_open();
      i_host.shift(1, 24, 32'h00A5_1234, 1'b1, r);
      chk("ignored opcode", sio_oe_n, 4'hF);
      i_host.frame_close();
      set_mode(sscp_pkg::MODE_SEQ);
      for (int w = 2; w <= 4; w += 2) begin
         cmd(1, (w == 2) ? sscp_pkg::ENTER_DUAL : sscp_pkg::ENTER_QUAD, 0, 8'h00, 1'b0);
         a = 24'($urandom);
         mem_write(w, a, 5);
         mem_read(w, a, 5);
         mode_chk(w);
         cmd(w, sscp_pkg::EXIT_WIDE, 0, 8'h00, 1'b0);
         mode_chk(1);
      end
      end_sim();
   end

   // A hang is cut off well beyond the expected run of about 16000 cycles.
   initial begin
      repeat (90000) @(posedge clk);
      n_errors++;
      $display("mismatch watchdog expected done seen hang");
      end_sim();
   end
endmodule

// >>> tb/sscp_host.sv
module sscp_host (
   input  wire logic       clk,
   input  wire logic [3:0] sio_wire,
   output      logic       cs_n,
   output      logic       sck,
   output      logic [3:0] host_drv
);
   timeunit 1ns;
   timeprecision 1ps;

   // Select rests high and the clock rests low outside frames.
   initial begin
      cs_n     = 1'b1;
      sck      = 1'b0;
      host_drv = 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Select falls only from a high level, so even the first frame sees a falling edge.
   task automatic frame_open();
      @(negedge clk);
      cs_n = 1'b0;
      repeat (4) @(negedge clk);
   endtask

   // The clock is parked low in the same step as select rises; released lines flip so no stale value lingers.
   task automatic frame_close();
      @(negedge clk);
      sck      = 1'b0;
      cs_n     = 1'b1;
      host_drv = ~host_drv;
      repeat (8) @(negedge clk);
   endtask

   // Moves nbits at w bits per clock, most significant first; the link clock period is 64 ns.
   // Edges fall on whole nanoseconds, never on a system clock rising edge.
   task automatic shift(input int w, input int nbits, input logic [31:0] tx, input bit drv,
                        output logic [31:0] rx);
      logic [3:0] m;
      logic [3:0] lanes;
      m  = 4'((1 << w) - 1);
      rx = '0;
      for (int i = nbits - w; i >= 0; i -= w) begin
         sck   = 1'b0;
         lanes = 4'(tx >> i) & m;
         host_drv = drv ? ((lanes & m) | (~host_drv & ~m)) : ~host_drv;
         #32;
         sck = 1'b1;
         rx  = (rx << w) | ((w == 1) ? 32'(sio_wire[1]) : 32'(sio_wire & m));
         #32;
      end
   endtask
endmodule
